/* File: rtl/fpep_err.sv */
`timescale 1ns/1ps
`default_nettype none
module fpep_err import fpep_pkg::*;
(
    // Clock, power-on reset, enable
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    // Shared signals
    fpep_if.err_mp    lnk
);
    // Module state
    typedef struct packed {
        logic fault; // Sticky fault flag
    } fpep_err_st_t;

    fpep_err_st_t st;      // Current state
    fpep_err_st_t next_st; // Next state

    // Any illegal event while an operation runs
    assign lnk.hit = lnk.op_active &&
        (lnk.array_rd || lnk.exc_start || lnk.sleep_exec);

    // Flag only ever sets here; no clear path but reset
    always_comb
    begin
        next_st = st;
        if (lnk.hit)
        begin
            next_st.fault = 1'b1;
        end
    end

    // Only the power-on reset reaches this flop
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign lnk.fault = st.fault;
endmodule
`default_nettype wire

/* File: rtl/fpep_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fpep_if import fpep_pkg::*;;
    logic       op_active;  // Program or erase mode on
    logic       array_rd;   // Array read, fetch or vector
    logic       exc_start;  // Non-reset exception begins
    logic       sleep_exec; // Sleep instruction executed
    logic       hit;        // Error seen this cycle
    logic       fault;      // Sticky fault flag
    fpep_mode_t mode;       // Chip operating mode
    logic       inhibit;    // Subclock low-power inhibit
    fpep_fpwr_t pwr_state;  // Flash power state
    logic       read_only;  // Array is read-only

    // Top side
    modport top_mp (
        output op_active, array_rd, exc_start, sleep_exec,
        output mode, inhibit,
        input  hit, fault, pwr_state, read_only
    );

    // Error detector side
    modport err_mp (
        input  op_active, array_rd, exc_start, sleep_exec,
        output hit, fault
    );

    // Power mapper side
    modport pwr_mp (
        input  mode, inhibit,
        output pwr_state, read_only
    );
endinterface
`default_nettype wire

/* File: rtl/fpep_pkg.sv */
package fpep_pkg;

    // Register byte addresses
    localparam logic [15:0] FPEP_RAMEMU_ADDR = 16'hfedb;
    localparam logic [15:0] FPEP_CTL1_ADDR   = 16'hffa8;
    localparam logic [15:0] FPEP_CTL2_ADDR   = 16'hffa9;
    localparam logic [15:0] FPEP_ERASE_BLOCK_SELECT_ONE_ADDR   = 16'hffaa;
    localparam logic [15:0] FPEP_ERASE_BLOCK_SELECT_TWO_ADDR   = 16'hffab;
    localparam logic [15:0] FPEP_FLPW_ADDR   = 16'hffac;
    localparam logic [15:0] FPEP_ISTS_ADDR   = 16'hffad;
    localparam logic [15:0] FPEP_IMSK_ADDR   = 16'hffae;

    // Field positions
    localparam int FPEP_PROG_BIT  = 0;
    localparam int FPEP_ERASE_BIT = 1;
    localparam int FPEP_PCHK_BIT  = 2;
    localparam int FPEP_WCHK_BIT  = 3;
    localparam int FPEP_WGATE_BIT = 6;
    localparam int FPEP_FAULT_BIT = 7;
    localparam int FPEP_INHIB_BIT = 7;
    localparam int FPEP_EV_FAULT  = 0;
    localparam int FPEP_EV_ABORT  = 1;

    // Writable bits of the first control register
    localparam logic [7:0] FPEP_CTL1_WMASK = 8'h4f;

    // Reset values
    localparam logic [7:0] FPEP_CTL1_RST   = 8'h00;
    localparam logic [7:0] FPEP_EBR_RST    = 8'h00;
    localparam logic [7:0] FPEP_FLPW_RST   = 8'h00;
    localparam logic [7:0] FPEP_RAMEMU_RST = 8'h00;
    localparam logic [1:0] FPEP_IRQ_RST    = 2'h0;

    // Chip operating modes
    typedef enum logic [2:0] {
        MODE_HIGH,
        MODE_MEDIUM,
        MODE_SLEEP,
        MODE_SUBACT,
        MODE_SUBSLP,
        MODE_WATCH,
        MODE_SWSTBY,
        MODE_HWSTBY
    } fpep_mode_t;

    // Flash power states
    typedef enum logic [1:0] {
        FPWR_NORMAL,
        FPWR_REDUCED,
        FPWR_HALTED
    } fpep_fpwr_t;

    // Any of the three standby modes
    function automatic logic fpep_in_standby(input fpep_mode_t m);
        return (m == MODE_WATCH) || (m == MODE_SWSTBY) ||
               (m == MODE_HWSTBY);
    endfunction

    // Running from the subclock
    function automatic logic fpep_on_subclock(input fpep_mode_t m);
        return (m == MODE_SUBACT) || (m == MODE_SUBSLP);
    endfunction

endpackage

/* File: rtl/fpep_pwr.sv */
`timescale 1ns/1ps
`default_nettype none
module fpep_pwr import fpep_pkg::*;
(
    // Clock, reset, enable
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    // Shared signals
    fpep_if.pwr_mp    lnk
);
    // Module state
    typedef struct packed {
        fpep_fpwr_t pwr; // Flash power state
        logic       ro;  // Read-only
    } fpep_pwr_st_t;

    fpep_pwr_st_t st;      // Current state
    fpep_pwr_st_t next_st; // Next state

    // Map chip mode to flash power
    always_comb
    begin
        next_st.pwr = FPWR_NORMAL;
        next_st.ro  = 1'b0;
        if (fpep_in_standby(lnk.mode))
        begin
            next_st.pwr = FPWR_HALTED;
        end
        else if (fpep_on_subclock(lnk.mode))
        begin
            // Inhibit keeps full power at a current cost
            next_st.pwr = lnk.inhibit ? FPWR_NORMAL : FPWR_REDUCED;
            next_st.ro  = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '{pwr: FPWR_NORMAL, ro: 1'b0};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign lnk.pwr_state = st.pwr;
    assign lnk.read_only = st.ro;
endmodule
`default_nettype wire

/* File: rtl/fpep_top.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpep_top import fpep_pkg::*;
(
    // Clock, power-on reset, enable
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    // Register port
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Chip status, same clock
    input  wire logic        SYS_RST,
    input  wire logic [2:0]  CHIP_MODE,
    input  wire logic        BOOT_ACTIVE,
    input  wire logic        ARRAY_RD,
    input  wire logic        EXC_START,
    input  wire logic        SLEEP_EXEC,
    // Flash control outputs
    output logic             IRQ_BLOCK,
    output logic             PROG_MODE,
    output logic             ERASE_MODE,
    output logic             PCHK_MODE,
    output logic             WCHK_MODE,
    output logic      [7:0]  ERASE_BLK_EN,
    output logic      [1:0]  FLASH_PWR,
    output logic             FLASH_RO,
    output logic             FAULT,
    // Interrupt
    output logic             IRQ
);
    // Module state
    typedef struct packed {
        logic [7:0] ctl1;     // First control register
        logic [7:0] erase_block_select_one;     // Erase block select one
        logic [7:0] erase_block_select_two;     // Erase block select two
        logic [7:0] flpw;     // Flash power control
        logic [7:0] ramemu;   // RAM emulation control
        logic [1:0] ists;     // Sticky event status
        logic [1:0] imask;    // Event mask
        logic [7:0] rdata;    // Read data
        logic       prog_on;  // Program mode
        logic       erase_on; // Erase mode
        logic       pchk_on;  // Program verify mode
        logic       wchk_on;  // Erase verify mode
        logic [7:0] blk_en;   // Active erase blocks
    } fpep_top_st_t;

    // Register picked by a bus address
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_CTL1,
        SEL_CTL2,
        SEL_ERASE_BLOCK_SELECT_ONE,
        SEL_ERASE_BLOCK_SELECT_TWO,
        SEL_FLPW,
        SEL_RAMEMU,
        SEL_ISTS,
        SEL_IMSK
    } fpep_sel_t;

    // Shared by the write and read paths so they never disagree
    // Plain if chain: the addresses are sparse
    function automatic fpep_sel_t fpep_decode(input logic [15:0] a);
        fpep_sel_t s; // Decoded register

        // Anything unmapped stays at none
        s = SEL_NONE;
        if (a == FPEP_CTL1_ADDR)
        begin
            s = SEL_CTL1;
        end
        else if (a == FPEP_CTL2_ADDR)
        begin
            s = SEL_CTL2;
        end
        else if (a == FPEP_ERASE_BLOCK_SELECT_ONE_ADDR)
        begin
            s = SEL_ERASE_BLOCK_SELECT_ONE;
        end
        else if (a == FPEP_ERASE_BLOCK_SELECT_TWO_ADDR)
        begin
            s = SEL_ERASE_BLOCK_SELECT_TWO;
        end
        else if (a == FPEP_FLPW_ADDR)
        begin
            s = SEL_FLPW;
        end
        else if (a == FPEP_RAMEMU_ADDR)
        begin
            s = SEL_RAMEMU;
        end
        else if (a == FPEP_ISTS_ADDR)
        begin
            s = SEL_ISTS;
        end
        else if (a == FPEP_IMSK_ADDR)
        begin
            s = SEL_IMSK;
        end
        return s;
    endfunction

    fpep_top_st_t st;       // Current state
    fpep_top_st_t next_st;  // Next state
    fpep_mode_t   mode;     // Typed chip mode
    logic         hw_prot;  // Reset or standby protection
    logic         gate;     // Write gate set
    logic         allow_op; // Program or erase may run
    fpep_sel_t    sel;      // Register picked by ADDR

    // Signals shared with the two helpers
    fpep_if lnk ();

    // Error detector
    fpep_err u_err (
        .clk  (CLK),
        .srst (SRST),
        .ce   (CE),
        .lnk  (lnk)
    );

    // Power-state mapper
    fpep_pwr u_pwr (
        .clk  (CLK),
        .srst (SRST),
        .ce   (CE),
        .lnk  (lnk)
    );

    // Typed chip mode, codes match the enum order
    assign mode           = fpep_mode_t'(CHIP_MODE);
    // Chip mode and inhibit bit to the power mapper
    assign lnk.mode       = mode;
    assign lnk.inhibit    = st.flpw[FPEP_INHIB_BIT];
    // Operation state and raw events to the detector
    assign lnk.op_active  = st.prog_on || st.erase_on;
    assign lnk.array_rd   = ARRAY_RD;
    assign lnk.exc_start  = EXC_START;
    assign lnk.sleep_exec = SLEEP_EXEC;

    // Standby or a non-power-on reset forces protection
    assign hw_prot = SYS_RST || fpep_in_standby(mode);
    // Software write gate
    assign gate    = st.ctl1[FPEP_WGATE_BIT];

    // One decode feeds both the write and the read path
    assign sel     = fpep_decode(ADDR);

    // Error ends the mode in the same edge the flag sets
    assign allow_op = gate && !lnk.fault && !lnk.hit && !hw_prot &&
                      !lnk.read_only;

    // Next-state logic; order matters: writes first, then
    // events so a set beats a clear, then protection last
    always_comb
    begin
        // Hold by default; read data drops back to zero
        next_st       = st;
        next_st.rdata = 8'h00;

        // Register writes; unmapped addresses fall through
        if (WR)
        begin
            case (sel)
                SEL_CTL1:
                begin
                    // Stored even when refused, so contents survive
                    next_st.ctl1 = WDATA & FPEP_CTL1_WMASK;
                end
                SEL_CTL2:
                begin
                    // Fault flag is not software writable
                    next_st.ctl1 = st.ctl1;
                end
                SEL_ERASE_BLOCK_SELECT_ONE:
                begin
                    // One erase enable per block
                    next_st.erase_block_select_one = WDATA;
                end
                SEL_ERASE_BLOCK_SELECT_TWO:
                begin
                    // Plain storage, kept through protection
                    next_st.erase_block_select_two = WDATA;
                end
                SEL_FLPW:
                begin
                    // Only the inhibit bit is stored
                    next_st.flpw = WDATA & (8'h01 << FPEP_INHIB_BIT);
                end
                SEL_RAMEMU:
                begin
                    // Whole byte stored
                    next_st.ramemu = WDATA;
                end
                SEL_ISTS:
                begin
                    // Write one to clear
                    next_st.ists = st.ists & ~WDATA[1:0];
                end
                SEL_IMSK:
                begin
                    // Mask has the status layout
                    next_st.imask = WDATA[1:0];
                end
                default:
                begin
                    // Unmapped address, write ignored
                end
            endcase
        end

        // Register reads, data stands one cycle
        if (RD)
        begin
            case (sel)
                SEL_CTL1:
                begin
                    // Unused bits already read as zero
                    next_st.rdata = st.ctl1;
                end
                SEL_CTL2:
                begin
                    // Only the fault flag shows
                    next_st.rdata[FPEP_FAULT_BIT] = lnk.fault;
                end
                SEL_ERASE_BLOCK_SELECT_ONE:
                begin
                    // First erase select
                    next_st.rdata = st.erase_block_select_one;
                end
                SEL_ERASE_BLOCK_SELECT_TWO:
                begin
                    // Second erase select
                    next_st.rdata = st.erase_block_select_two;
                end
                SEL_FLPW:
                begin
                    // Inhibit bit, others zero
                    next_st.rdata = st.flpw;
                end
                SEL_RAMEMU:
                begin
                    // RAM emulation byte
                    next_st.rdata = st.ramemu;
                end
                SEL_ISTS:
                begin
                    // Sticky event status
                    next_st.rdata = {6'h00, st.ists};
                end
                SEL_IMSK:
                begin
                    // Event mask
                    next_st.rdata = {6'h00, st.imask};
                end
                default:
                begin
                    // Unmapped address reads as zero
                end
            endcase
        end

        // Events set after the clear so the set wins
        // Fault event only on the edge the flag first sets
        if (lnk.hit && !lnk.fault)
        begin
            next_st.ists[FPEP_EV_FAULT] = 1'b1;
        end
        // Abort event only when a mode was really cut off
        if (hw_prot && lnk.op_active)
        begin
            next_st.ists[FPEP_EV_ABORT] = 1'b1;
        end

        // Protection overrides a write in the same cycle
        if (hw_prot)
        begin
            next_st.ctl1 = FPEP_CTL1_RST;
            next_st.erase_block_select_one = FPEP_EBR_RST;
            // Select two and power bits are left alone
        end

        // Flash modes; verify still allowed under fault
        // Program and erase follow the bits a cycle late
        next_st.prog_on  = allow_op && st.ctl1[FPEP_PROG_BIT];
        next_st.erase_on = allow_op && st.ctl1[FPEP_ERASE_BIT];
        // Verify ignores the fault, not the gate
        next_st.pchk_on  = gate && !hw_prot &&
                           st.ctl1[FPEP_PCHK_BIT];
        next_st.wchk_on  = gate && !hw_prot &&
                           st.ctl1[FPEP_WCHK_BIT];
        // All-zero select leaves every block protected
        next_st.blk_en   = next_st.erase_on ? st.erase_block_select_one : 8'h00;
    end

    // State register; fault flag lives in the detector
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            // Clear everything, then the named reset values
            st        <= '0;
            st.ctl1   <= FPEP_CTL1_RST;
            st.erase_block_select_one   <= FPEP_EBR_RST;
            st.erase_block_select_two   <= FPEP_EBR_RST;
            st.flpw   <= FPEP_FLPW_RST;
            st.ramemu <= FPEP_RAMEMU_RST;
            st.ists   <= FPEP_IRQ_RST;
            st.imask  <= FPEP_IRQ_RST;
        end
        else if (CE)
        begin
            // Frozen while the enable is low
            st <= next_st;
        end
    end

    // Interrupt gating covers the non-maskable one too
    assign IRQ_BLOCK    = lnk.op_active || BOOT_ACTIVE;

    // Program and erase modes
    assign PROG_MODE    = st.prog_on;
    assign ERASE_MODE   = st.erase_on;
    // Verify modes
    assign PCHK_MODE    = st.pchk_on;
    assign WCHK_MODE    = st.wchk_on;
    // Blocks open for erase, zero outside erase mode
    assign ERASE_BLK_EN = st.blk_en;

    // Flash power state and read-only flag
    assign FLASH_PWR    = lnk.pwr_state;
    assign FLASH_RO     = lnk.read_only;
    // Sticky fault, survives all but power-on reset
    assign FAULT        = lnk.fault;

    // Read data stands one cycle after the strobe
    assign RDATA        = st.rdata;
    // Level interrupt from unmasked status bits
    assign IRQ          = |(st.ists & st.imask);
endmodule
`default_nettype wire

/* File: verif/fpep_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
module fpep_cpu import fpep_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Register port, master side
    output var  logic [15:0] addr,
    output var  logic [7:0]  wdata,
    output var  logic        wr,
    output var  logic        rd,
    input  wire logic [7:0]  rdata
);
    // Quiet bus at time zero
    initial
    begin
        addr  = 16'h0000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One-cycle write; stale data inverted so it never looks valid
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask

    // One-cycle read; data taken mid cycle, away from the edge
    task automatic get(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Erase pass on exactly one block; several blocks go in turn
    task automatic wipe(input logic [2:0] b);
        put(FPEP_ERASE_BLOCK_SELECT_ONE_ADDR, 8'h01 << b);
        put(FPEP_CTL1_ADDR, 8'h42);
    endtask
endmodule
`default_nettype wire

/* File: verif/fpep_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fpep_monitor import fpep_pkg::*;
(
    // Clock, reset, enable
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        CE,
    // Bus and chip status
    input wire logic [15:0] ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        SYS_RST,
    input wire logic [2:0]  CHIP_MODE,
    input wire logic        BOOT_ACTIVE,
    input wire logic        ARRAY_RD,
    input wire logic        EXC_START,
    input wire logic        SLEEP_EXEC,
    // Flash outputs
    input wire logic        IRQ_BLOCK,
    input wire logic        PROG_MODE,
    input wire logic        ERASE_MODE,
    input wire logic [7:0]  ERASE_BLK_EN,
    input wire logic [1:0]  FLASH_PWR,
    input wire logic        FLASH_RO,
    input wire logic        FAULT
);
    // Frozen cycles prove nothing, so they abort attempts
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST || !CE);
    logic op; // Program or erase running
    assign op = PROG_MODE | ERASE_MODE;

    chk_irq_block: assert property (IRQ_BLOCK == (op | BOOT_ACTIVE))
        else $error("irq block wrong");
    chk_error_latch: assert property
        (op && (ARRAY_RD || EXC_START || SLEEP_EXEC) |=> FAULT && !op)
        else $error("error not latched");
    chk_fault_sticky: assert property (FAULT |=> FAULT)
        else $error("fault flag lost");
    chk_fault_locks: assert property (FAULT |-> !op)
        else $error("mode under fault");
    chk_hw_abort: assert property
        (SYS_RST || CHIP_MODE >= 3'h5 |=> !op)
        else $error("mode survives reset");
    chk_gate_closed: assert property
        (WR && ADDR == FPEP_CTL1_ADDR && !WDATA[FPEP_WGATE_BIT] ##1 1 |=> !op)
        else $error("mode without gate");
    chk_block_mask: assert property
        (!ERASE_MODE |-> ERASE_BLK_EN == 8'h00)
        else $error("block enable leaks");
    chk_standby_halt: assert property
        (CHIP_MODE >= 3'h5 |=> FLASH_PWR == 2'h2)
        else $error("standby not halted");
    chk_sub_ro: assert property
        (CHIP_MODE inside {3'h3, 3'h4} |=> FLASH_RO && FLASH_PWR != 2'h2)
        else $error("subclock not read-only");
endmodule

bind fpep_top fpep_monitor mon (.CLK(CLK), .SRST(SRST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .SYS_RST(SYS_RST),
    .CHIP_MODE(CHIP_MODE), .BOOT_ACTIVE(BOOT_ACTIVE), .ARRAY_RD(ARRAY_RD),
    .EXC_START(EXC_START), .SLEEP_EXEC(SLEEP_EXEC), .IRQ_BLOCK(IRQ_BLOCK),
    .PROG_MODE(PROG_MODE), .ERASE_MODE(ERASE_MODE),
    .ERASE_BLK_EN(ERASE_BLK_EN), .FLASH_PWR(FLASH_PWR),
    .FLASH_RO(FLASH_RO), .FAULT(FAULT));
`default_nettype wire

/* File: verif/test_flash_program_erase_protection.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_protection import fpep_pkg::*;;
    // Stimulus
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        sys_rst = 1'b0;
    logic        boot = 1'b0;
    logic [2:0]  chip_mode = 3'h0;
    logic [2:0]  ev = 3'h0;  // Array read, exception, sleep
    // Bus and observed outputs
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, blk_en;
    logic        wr, rd, irq_blk, prog, erase, pchk, wchk, ro, fault, irq;
    logic [1:0]  pwr;
    int          miscompares = 0;
    int          comparisons = 0;

    always #25 clk = ~clk;

    fpep_cpu cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    fpep_top dut (.CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SYS_RST(sys_rst),
        .CHIP_MODE(chip_mode), .BOOT_ACTIVE(boot), .ARRAY_RD(ev[0]),
        .EXC_START(ev[1]), .SLEEP_EXEC(ev[2]), .IRQ_BLOCK(irq_blk),
        .PROG_MODE(prog), .ERASE_MODE(erase), .PCHK_MODE(pchk),
        .WCHK_MODE(wchk), .ERASE_BLK_EN(blk_en), .FLASH_PWR(pwr),
        .FLASH_RO(ro), .FAULT(fault), .IRQ(irq));

    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // Settle n edges, look mid cycle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu.get(a, d);
        chk("rdata", e, d);
    endtask

    // One-cycle pulse on the non-power-on reset
    task automatic pulse_rst;
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_regs;
        rchk(FPEP_CTL1_ADDR, FPEP_CTL1_RST);
        rchk(FPEP_FLPW_ADDR, FPEP_FLPW_RST);
        cpu.put(FPEP_RAMEMU_ADDR, 8'ha5);
        cpu.put(FPEP_ERASE_BLOCK_SELECT_TWO_ADDR, 8'h3c);
        cpu.put(16'hffb0, 8'hff);
        cpu.put(FPEP_CTL2_ADDR, 8'h80);
        rchk(FPEP_RAMEMU_ADDR, 8'ha5);
        // Enable low: a write must not land
        @(posedge clk);
        ce <= 1'b0;
        cpu.put(FPEP_RAMEMU_ADDR, 8'h5a);
        ce <= 1'b1;
        rchk(FPEP_RAMEMU_ADDR, 8'ha5);
        rchk(FPEP_ERASE_BLOCK_SELECT_TWO_ADDR, 8'h3c);
        rchk(16'hffb0, 8'h00);
        rchk(FPEP_CTL2_ADDR, 8'h00);
        cpu.put(FPEP_CTL1_ADDR, 8'h03);
        tick(1);
        chk("prog", 8'h00, prog);
        chk("erase", 8'h00, erase);
        @(posedge clk);
        boot <= 1'b1;
        tick(0);
        chk("irq_blk", 8'h01, irq_blk);
        @(posedge clk);
        boot <= 1'b0;
    endtask

    // Erase, hardware abort, abort interrupt
    task automatic t_erase;
        cpu.wipe(3'h2);
        tick(1);
        chk("erase", 8'h01, erase);
        chk("blk_en", 8'h04, blk_en);
        chk("irq_blk", 8'h01, irq_blk);
        pulse_rst();
        chk("erase", 8'h00, erase);
        rchk(FPEP_CTL1_ADDR, 8'h00);
        rchk(FPEP_ERASE_BLOCK_SELECT_ONE_ADDR, 8'h00);
        rchk(FPEP_ERASE_BLOCK_SELECT_TWO_ADDR, 8'h3c);
        cpu.put(FPEP_IMSK_ADDR, 8'h02);
        tick(1);
        chk("irq", 8'h01, irq);
        cpu.put(FPEP_IMSK_ADDR, 8'h00);
        tick(1);
        chk("irq", 8'h00, irq);
        cpu.put(FPEP_IMSK_ADDR, 8'h02);
        cpu.put(FPEP_ISTS_ADDR, 8'h02);
        tick(1);
        chk("irq", 8'h00, irq);
        cpu.put(FPEP_CTL1_ADDR, 8'h42);
        tick(1);
        chk("blk_en", 8'h00, blk_en);
    endtask

    task automatic t_power;
        for (int f = 0; f < 2; f++)
        begin
            cpu.put(FPEP_FLPW_ADDR, f ? 8'h80 : 8'h00);
            for (int m = 0; m < 8; m++)
            begin
                @(posedge clk);
                chip_mode <= m[2:0];
                tick(1);
                chk("pwr", m > 4 ? 8'h02 :
                    (m > 2 && f == 0) ? 8'h01 : 8'h00, pwr);
                chk("ro", (m == 3 || m == 4) ? 8'h01 : 8'h00, ro);
            end
        end
        @(posedge clk);
        chip_mode <= 3'h0;
    endtask

    // Each fault source in turn, from a fresh power-on reset
    task automatic t_error;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            srst <= 1'b1;
            repeat (2) @(posedge clk);
            srst <= 1'b0;
            cpu.put(FPEP_CTL1_ADDR, 8'h41);
            tick(1);
            chk("prog", 8'h01, prog);
            @(posedge clk);
            ev <= 3'h1 << k;
            @(posedge clk);
            ev <= 3'h0;
            @(negedge clk);
            chk("fault", 8'h01, fault);
            chk("prog", 8'h00, prog);
            rchk(FPEP_CTL1_ADDR, 8'h41);
            cpu.put(FPEP_CTL2_ADDR, 8'h00);
            rchk(FPEP_CTL2_ADDR, 8'h80);
            cpu.put(FPEP_IMSK_ADDR, 8'h01);
            tick(1);
            chk("irq", 8'h01, irq);
            cpu.put(FPEP_CTL1_ADDR, 8'h4d);
            tick(1);
            chk("prog", 8'h00, prog);
            chk("pchk", 8'h01, pchk);
            chk("wchk", 8'h01, wchk);
            pulse_rst();
            chk("fault", 8'h01, fault);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_erase();
        t_power();
        t_error();
        end_of_test();
    end

    // Whole run needs well under 1000 cycles; 20000 means a hang
    initial
    begin
        #1000000;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
